// *** inc/rpc_pkg.sv ***
// Constants and types shared by the root-port control and status block.
// Assumes configuration accesses arrive as dword-aligned byte addresses.
package rpc_pkg;

  // Configuration-space byte offsets of the three registers.
  localparam logic [11:0] ROOT_CONTROL_OFFSET = 12'h0bc;
  localparam logic [11:0] ROOT_STATUS_OFFSET = 12'h0c0;
  localparam logic [11:0] LEGACY_EVENT_CONTROL_OFFSET = 12'h0ec;

  // Values after reset.
  localparam logic [15:0] ROOT_CONTROL_RESET = 16'h0000;
  localparam logic [31:0] ROOT_STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] LEGACY_EVENT_CONTROL_RESET = 32'h0000_0000;

  // Root control field positions.
  localparam int CTL_PME_INT_ENABLE_BIT = 3;
  localparam int CTL_SYSERR_FATAL_BIT = 2;
  localparam int CTL_SYSERR_NONFATAL_BIT = 1;
  localparam int CTL_SYSERR_CORR_BIT = 0;
  localparam int CTL_WIDTH = 4;

  // Root status field positions.
  localparam int STS_PME_PENDING_BIT = 17;
  localparam int STS_PME_STATUS_BIT = 16;
  localparam int STS_RID_WIDTH = 16;

  // Legacy event control field positions.
  localparam int LEG_PME_TO_GPE_BIT = 2;
  localparam int LEG_GPE_FORWARD_BIT = 0;

  // Byte lanes that carry the writable fields.
  localparam int CTL_BYTE_LANE = 0;
  localparam int STS_STATUS_BYTE_LANE = 2;
  localparam int LEG_BYTE_LANE = 0;

  // Depth of the queue that holds Pme_status waiting behind a set status bit.
  localparam int PME_QUEUE_DEPTH = 4;
  localparam int PME_QUEUE_PTR_WIDTH = 2;

  typedef enum logic {
    GPE_IDLE,
    GPE_ASSERTED
  } rpc_gpe_state_type;

endpackage

// *** rtl/rpc_pme_queue.sv ***
// Queue of PME requester identifiers that wait while PME status is set.
// Assumes the owner pops only when it takes the head into status.
`timescale 1ns/100ps
`default_nettype none
module rpc_pme_queue #(
  parameter int WIDTH = rpc_pkg::STS_RID_WIDTH,
  parameter int DEPTH = rpc_pkg::PME_QUEUE_DEPTH,
  parameter int PTR_WIDTH = rpc_pkg::PME_QUEUE_PTR_WIDTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic push_in,
  input wire logic [WIDTH-1:0] push_data_in,
  input wire logic pop_in,
  output logic [WIDTH-1:0] head_out,
  output logic empty_out,
  output logic full_out
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_WIDTH-1:0] wptr;
    logic [PTR_WIDTH-1:0] rptr;
    logic [PTR_WIDTH:0] count;
  } rpc_queue_state_type;

  rpc_queue_state_type st;
  rpc_queue_state_type next_st;
  logic push_ok;
  logic pop_ok;

  // A push into a full queue is allowed only when the head leaves in the same cycle.
  assign pop_ok = pop_in & ~empty_out;
  assign push_ok = push_in & (~full_out | pop_ok);

  always_comb begin
    next_st = st;
    if (push_ok) begin
      next_st.mem[st.wptr] = push_data_in;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (pop_ok) begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (push_ok && !pop_ok) begin
      next_st.count = st.count + 1'b1;
    end else if (pop_ok && !push_ok) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign head_out = st.mem[st.rptr];
  assign empty_out = (st.count == '0);
  assign full_out = (st.count == DEPTH[PTR_WIDTH:0]);

  a_queue_drains: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    (st.count == 1) && pop_in && !push_in |=> empty_out)
    else $error("Queue not empty after its last entry left.");

endmodule // rpc_pme_queue
`default_nettype wire

// *** rtl/rpc_root_port_ctl.sv ***
// Root-port control and status: system-error gating, PME capture and queueing,
// PME interrupt and legacy general-purpose-event messages.
// Assumes configuration reads and writes come as one-cycle strobes on the core clock
// and that link-side message pulses come from logic on the same clock.
//
// Notes on behaviour
// - With the PME interrupt enable clear no interrupt is raised for Pme_status.
// - With the PME interrupt enable set a recorded PME raises the interrupt.
// - Setting the PME interrupt enable while PME status is set raises the interrupt at once.
// - A fatal error from the port or below raises a system error only if its enable is set.
// - A non-fatal error raises a system error only if its enable is set.
// - A correctable error raises a system error only if its enable is set.
// - The severity enables apply both to own detected errors and to received error messages.
// - The severity enables alone decide, and no generic command-register enable overrides them.
// - An accepted PME sets PME status and records the requester identifier in bits 15:0.
// - Software clears PME status by writing one, and while set the recorded PME is kept.
// - The read-only pending flag shows that another PME waits while status is set.
// - After status is cleared a waiting PME is delivered with its identifier.
// - The pending flag clears itself once no PME waits.
// - With PME-to-event enabled a received PME sends assert and later deassert messages.
// - With forwarding enabled received event messages go upstream, otherwise they are dropped.
// - Root control reads zero after reset, so every enable starts off.
`timescale 1ns/100ps
`default_nettype none
module rpc_root_port_ctl (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [11:0] cfg_addr_in,
  input wire logic [3:0] cfg_be_in,
  input wire logic [31:0] cfg_wdata_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rd_valid_out,
  input wire logic dev_err_fatal_in,
  input wire logic dev_err_nonfatal_in,
  input wire logic dev_err_corr_in,
  input wire logic msg_err_fatal_in,
  input wire logic msg_err_nonfatal_in,
  input wire logic msg_err_corr_in,
  output logic syserr_out,
  input wire logic pme_msg_valid_in,
  input wire logic [15:0] pme_msg_rid_in,
  output logic pme_msg_ready_out,
  output logic pme_int_out,
  input wire logic gpe_assert_msg_in,
  input wire logic gpe_deassert_msg_in,
  output logic pme_gpe_assert_msg_out,
  output logic pme_gpe_deassert_msg_out,
  output logic gpe_assert_msg_out,
  output logic gpe_deassert_msg_out
);

  typedef struct packed {
    logic [rpc_pkg::CTL_WIDTH-1:0] ctl;
    logic pme_to_gpe_enable;
    logic gpe_forward_enable;
    logic pme_status;
    logic [rpc_pkg::STS_RID_WIDTH-1:0] pme_requester_id;
    logic pme_int;
    rpc_pkg::rpc_gpe_state_type gpe_state;
    logic pme_gpe_assert_msg;
    logic pme_gpe_deassert_msg;
    logic gpe_assert_msg;
    logic gpe_deassert_msg;
    logic [31:0] rdata;
    logic rd_valid;
  } rpc_main_state_type;

  rpc_main_state_type st;
  rpc_main_state_type next_st;

  logic ctl_sel;
  logic sts_sel;
  logic leg_sel;
  logic sts_clear;
  logic status_free;
  logic pme_accept;
  logic pme_load;
  logic queue_push;
  logic queue_pop;
  logic [15:0] queue_head;
  logic queue_empty;
  logic queue_full;
  logic hit_fatal;
  logic hit_nonfatal;
  logic hit_corr;

  assign ctl_sel = (cfg_addr_in[11:2] == rpc_pkg::ROOT_CONTROL_OFFSET[11:2]);
  assign sts_sel = (cfg_addr_in[11:2] == rpc_pkg::ROOT_STATUS_OFFSET[11:2]);
  assign leg_sel = (cfg_addr_in[11:2] == rpc_pkg::LEGACY_EVENT_CONTROL_OFFSET[11:2]);

  // Write-one-to-clear of PME status on its own byte lane.
  assign sts_clear = cfg_wr_in & sts_sel & cfg_be_in[rpc_pkg::STS_STATUS_BYTE_LANE]
    & cfg_wdata_in[rpc_pkg::STS_PME_STATUS_BIT];

  // Status is free for a new PME when it is clear or being cleared this very cycle,
  // so a PME arriving with the clear is never lost.
  assign status_free = ~st.pme_status | sts_clear;
  assign pme_msg_ready_out = ~queue_full | status_free;
  assign pme_accept = pme_msg_valid_in & pme_msg_ready_out;

  rpc_pme_queue u_queue (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .push_in(queue_push),
    .push_data_in(pme_msg_rid_in),
    .pop_in(queue_pop),
    .head_out(queue_head),
    .empty_out(queue_empty),
    .full_out(queue_full)
  );

  rpc_sev_gate u_gate_fatal (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(st.ctl[rpc_pkg::CTL_SYSERR_FATAL_BIT]),
    .own_err_in(dev_err_fatal_in),
    .msg_err_in(msg_err_fatal_in),
    .hit_out(hit_fatal)
  );

  rpc_sev_gate u_gate_nonfatal (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(st.ctl[rpc_pkg::CTL_SYSERR_NONFATAL_BIT]),
    .own_err_in(dev_err_nonfatal_in),
    .msg_err_in(msg_err_nonfatal_in),
    .hit_out(hit_nonfatal)
  );

  rpc_sev_gate u_gate_corr (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .enable_in(st.ctl[rpc_pkg::CTL_SYSERR_CORR_BIT]),
    .own_err_in(dev_err_corr_in),
    .msg_err_in(msg_err_corr_in),
    .hit_out(hit_corr)
  );

  // The generic command-register error enable has no input here on purpose.
  assign syserr_out = hit_fatal | hit_nonfatal | hit_corr;

  always_comb begin
    next_st = st;
    next_st.pme_gpe_assert_msg = 1'b0;
    next_st.pme_gpe_deassert_msg = 1'b0;
    next_st.rd_valid = 1'b0;
    pme_load = 1'b0;
    queue_pop = 1'b0;
    queue_push = 1'b0;

    // Only the defined bits are stored; the rest of each word is dropped.
    if (cfg_wr_in && ctl_sel && cfg_be_in[rpc_pkg::CTL_BYTE_LANE]) begin
      next_st.ctl = cfg_wdata_in[rpc_pkg::CTL_WIDTH-1:0];
    end
    if (cfg_wr_in && leg_sel && cfg_be_in[rpc_pkg::LEG_BYTE_LANE]) begin
      next_st.pme_to_gpe_enable = cfg_wdata_in[rpc_pkg::LEG_PME_TO_GPE_BIT];
      next_st.gpe_forward_enable = cfg_wdata_in[rpc_pkg::LEG_GPE_FORWARD_BIT];
    end

    // PME capture: a waiting PME goes first, a new one queues behind it.
    if (status_free) begin
      if (!queue_empty) begin
        queue_pop = 1'b1;
        queue_push = pme_accept;
        next_st.pme_requester_id = queue_head;
        pme_load = 1'b1;
      end else if (pme_accept) begin
        next_st.pme_requester_id = pme_msg_rid_in;
        pme_load = 1'b1;
      end
      next_st.pme_status = pme_load;
    end else begin
      queue_push = pme_accept;
    end

    // Level interrupt follows enable and status, which also covers a late enable.
    next_st.pme_int = next_st.ctl[rpc_pkg::CTL_PME_INT_ENABLE_BIT] & next_st.pme_status;

    // Legacy event messages tied to PME delivery.
    unique case (st.gpe_state)
      rpc_pkg::GPE_IDLE: begin
        if (pme_load && st.pme_to_gpe_enable) begin
          next_st.pme_gpe_assert_msg = 1'b1;
          next_st.gpe_state = rpc_pkg::GPE_ASSERTED;
        end
      end
      rpc_pkg::GPE_ASSERTED: begin
        if (!next_st.pme_status) begin
          next_st.pme_gpe_deassert_msg = 1'b1;
          next_st.gpe_state = rpc_pkg::GPE_IDLE;
        end
      end
    endcase

    // Received event messages are relayed one cycle later or dropped.
    next_st.gpe_assert_msg = gpe_assert_msg_in & st.gpe_forward_enable;
    next_st.gpe_deassert_msg = gpe_deassert_msg_in & st.gpe_forward_enable;

    // Read data is taken one cycle after the strobe; unmapped words read zero.
    if (cfg_rd_in) begin
      next_st.rd_valid = 1'b1;
      next_st.rdata = '0;
      if (ctl_sel) begin
        next_st.rdata[rpc_pkg::CTL_WIDTH-1:0] = st.ctl;
      end else if (sts_sel) begin
        next_st.rdata[rpc_pkg::STS_PME_PENDING_BIT] = ~queue_empty;
        next_st.rdata[rpc_pkg::STS_PME_STATUS_BIT] = st.pme_status;
        next_st.rdata[rpc_pkg::STS_RID_WIDTH-1:0] = st.pme_requester_id;
      end else if (leg_sel) begin
        next_st.rdata[rpc_pkg::LEG_PME_TO_GPE_BIT] = st.pme_to_gpe_enable;
        next_st.rdata[rpc_pkg::LEG_GPE_FORWARD_BIT] = st.gpe_forward_enable;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
      st.ctl <= rpc_pkg::ROOT_CONTROL_RESET[rpc_pkg::CTL_WIDTH-1:0];
      st.pme_status <= rpc_pkg::ROOT_STATUS_RESET[rpc_pkg::STS_PME_STATUS_BIT];
      st.pme_requester_id <= rpc_pkg::ROOT_STATUS_RESET[rpc_pkg::STS_RID_WIDTH-1:0];
      st.pme_to_gpe_enable <= rpc_pkg::LEGACY_EVENT_CONTROL_RESET[rpc_pkg::LEG_PME_TO_GPE_BIT];
      st.gpe_forward_enable <= rpc_pkg::LEGACY_EVENT_CONTROL_RESET[rpc_pkg::LEG_GPE_FORWARD_BIT];
      st.gpe_state <= rpc_pkg::GPE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata_out = st.rdata;
  assign cfg_rd_valid_out = st.rd_valid;
  assign pme_int_out = st.pme_int;
  assign pme_gpe_assert_msg_out = st.pme_gpe_assert_msg;
  assign pme_gpe_deassert_msg_out = st.pme_gpe_deassert_msg;
  assign gpe_assert_msg_out = st.gpe_assert_msg;
  assign gpe_deassert_msg_out = st.gpe_deassert_msg;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_int_held_off: assert property (
    !st.ctl[rpc_pkg::CTL_PME_INT_ENABLE_BIT] |-> !pme_int_out)
    else $error("PME interrupt raised while its enable is clear.");

  a_int_on_pme: assert property (
    st.ctl[rpc_pkg::CTL_PME_INT_ENABLE_BIT] && st.pme_status |-> pme_int_out)
    else $error("Recorded PME did not raise the enabled interrupt.");

  a_int_late_enable: assert property (
    st.pme_status && !st.ctl[rpc_pkg::CTL_PME_INT_ENABLE_BIT] && cfg_wr_in && ctl_sel
    && cfg_be_in[0] && cfg_wdata_in[rpc_pkg::CTL_PME_INT_ENABLE_BIT] && !sts_clear
    |=> pme_int_out)
    else $error("Enabling the interrupt over a set status did not raise it.");

  a_fatal_syserr: assert property (
    st.ctl[rpc_pkg::CTL_SYSERR_FATAL_BIT] && dev_err_fatal_in |=> syserr_out)
    else $error("Enabled fatal error did not raise a system error.");

  a_syserr_quiet: assert property (
    !(st.ctl[2] && (dev_err_fatal_in || msg_err_fatal_in))
    && !(st.ctl[1] && (dev_err_nonfatal_in || msg_err_nonfatal_in))
    && !(st.ctl[0] && (dev_err_corr_in || msg_err_corr_in)) |=> !syserr_out)
    else $error("System error raised with no enabled error.");

  a_corr_syserr: assert property (
    st.ctl[rpc_pkg::CTL_SYSERR_CORR_BIT] && msg_err_corr_in |=> syserr_out)
    else $error("Enabled correctable error message did not raise a system error.");

  a_pme_capture: assert property (
    pme_accept && !st.pme_status && queue_empty
    |=> st.pme_status && st.pme_requester_id == $past(pme_msg_rid_in))
    else $error("Accepted PME not recorded with its requester.");

  a_pme_hold: assert property (
    st.pme_status && !sts_clear |=> st.pme_status && $stable(st.pme_requester_id))
    else $error("Recorded PME changed while status was set.");

  a_pending_status: assert property (
    !queue_empty |-> st.pme_status)
    else $error("A PME waits while status is clear.");

  a_pme_redeliver: assert property (
    sts_clear && st.pme_status && !queue_empty
    |=> st.pme_status && st.pme_requester_id == $past(queue_head))
    else $error("Waiting PME not delivered after the clear.");

  a_gpe_gated: assert property (
    !st.pme_to_gpe_enable && st.gpe_state == rpc_pkg::GPE_IDLE |=> !pme_gpe_assert_msg_out)
    else $error("PME event message sent while disabled.");

  a_gpe_forward: assert property (
    gpe_assert_msg_in |=> gpe_assert_msg_out == $past(st.gpe_forward_enable))
    else $error("Event message forwarding does not follow its enable.");

  a_ctl_reset: assert property (
    !$past(rst_n_in) |-> st.ctl == '0 && !pme_int_out && !syserr_out)
    else $error("Root control not zero after reset.");

  a_reserved_zero: assert property (
    cfg_rd_in && ctl_sel |=> cfg_rd_valid_out && cfg_rdata_out[31:4] == '0)
    else $error("Reserved root control bits read nonzero.");

  c_pme_queued: cover property (st.pme_status && pme_accept ##1 !queue_empty);
  c_pme_redeliver: cover property (sts_clear && !queue_empty);
  c_late_enable: cover property ($rose(pme_int_out) && $past(st.pme_status));
  c_syserr: cover property (syserr_out);

endmodule // rpc_root_port_ctl
`default_nettype wire

// *** rtl/rpc_sev_gate.sv ***
// One severity of system-error gating: own and received errors through an enable.
// Assumes both error inputs are one-cycle pulses on the core clock.
`timescale 1ns/100ps
`default_nettype none
module rpc_sev_gate (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic enable_in,
  input wire logic own_err_in,
  input wire logic msg_err_in,
  output logic hit_out
);

  typedef struct packed {
    logic hit;
  } rpc_gate_state_type;

  rpc_gate_state_type st;
  rpc_gate_state_type next_st;

  always_comb begin
    next_st = st;
    next_st.hit = enable_in & (own_err_in | msg_err_in);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit_out = st.hit;

  a_gate_blocks: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !enable_in |=> !hit_out)
    else $error("System error raised through a cleared enable.");

  a_gate_msg_path: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    enable_in && msg_err_in |=> hit_out)
    else $error("Received error message did not raise a system error.");

endmodule // rpc_sev_gate
`default_nettype wire

// *** tb/rpc_pme_src.sv ***
// Behavioural far-side source of PME messages for the root-port block.
// Assumes the single core clock and the block's valid and ready handshake.
`timescale 1ns/100ps
`default_nettype none
module rpc_pme_src (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic go_in,
  input wire logic [15:0] rid_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [15:0] rid_out
);
  logic [15:0] held;
  // A released id line shows the inverse of its last value, so a stale id never matches.
  assign rid_out = valid_out ? held : ~held;
  // The offer stands unchanged until the edge where ready is seen high.
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'h0;
      held <= 16'h0000;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'h0;
    end else if (go_in && !valid_out) begin
      valid_out <= 1'h1;
      held <= rid_in;
    end
  end
endmodule // rpc_pme_src
`default_nettype wire

// *** tb/test_root_port_error_pme_control.sv ***
// Self-checking bench for the root-port control and status block.
// Assumes a PME source model on the link side and a 40 MHz core clock.
`timescale 1ns/100ps
`default_nettype none
module test_root_port_error_pme_control;
  logic clk, rst_n, wr, rd, rd_valid, syserr, go, pme_valid, pme_ready, pme_int;
  logic gpe_a, gpe_d, o_pa, o_pd, o_ga, o_gd;
  logic [11:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, seed, d;
  logic [2:0] dev_err, msg_err;
  logic [15:0] go_rid, pme_rid;
  logic [15:0] r [4];
  logic [31:0] exp_q [$];
  int error_cnt, samples_checked, cnt [4], base [4];

  rpc_root_port_ctl u_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .cfg_wr_in(wr),
    .cfg_rd_in(rd), .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata),
    .cfg_rdata_out(rdata), .cfg_rd_valid_out(rd_valid), .dev_err_fatal_in(dev_err[2]),
    .dev_err_nonfatal_in(dev_err[1]), .dev_err_corr_in(dev_err[0]),
    .msg_err_fatal_in(msg_err[2]), .msg_err_nonfatal_in(msg_err[1]),
    .msg_err_corr_in(msg_err[0]), .syserr_out(syserr), .pme_msg_valid_in(pme_valid),
    .pme_msg_rid_in(pme_rid), .pme_msg_ready_out(pme_ready), .pme_int_out(pme_int),
    .gpe_assert_msg_in(gpe_a), .gpe_deassert_msg_in(gpe_d),
    .pme_gpe_assert_msg_out(o_pa), .pme_gpe_deassert_msg_out(o_pd),
    .gpe_assert_msg_out(o_ga), .gpe_deassert_msg_out(o_gd));

  rpc_pme_src u_src (.sys_clk_in(clk), .rst_n_in(rst_n), .go_in(go), .rid_in(go_rid),
    .ready_in(pme_ready), .valid_out(pme_valid), .rid_out(pme_rid));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic cfg_write(input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    be <= b;
    wdata <= v;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  // The expected word is noted when the read is launched and compared by the monitor.
  task automatic cfg_read(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    exp_q.push_back(v);
    @(posedge clk);
    rd <= 1'h0;
  endtask

  task automatic clear_sts();
    cfg_write(rpc_pkg::ROOT_STATUS_OFFSET, 4'h4, 32'h0001_0000);
  endtask

  task automatic err_pulse(input int s, input bit own, input logic exp);
    @(posedge clk);
    if (own) dev_err[s] <= 1'h1;
    else msg_err[s] <= 1'h1;
    @(posedge clk);
    dev_err <= 3'h0;
    msg_err <= 3'h0;
    // The gate answers one cycle after the pulse and stands for that cycle only.
    #1 check({31'h0, syserr}, {31'h0, exp});
  endtask

  // Waits a bounded span for the offer to be taken, then one edge so status lands.
  task automatic pme_send(input logic [15:0] id);
    @(posedge clk);
    go <= 1'h1;
    go_rid <= id;
    @(posedge clk);
    go <= 1'h0;
    for (int k = 0; k < 20; k++) begin
      @(posedge clk);
      if (pme_valid === 1'h0) break;
    end
  endtask

  task automatic gpe_pulse(input bit asrt);
    @(posedge clk);
    if (asrt) gpe_a <= 1'h1;
    else gpe_d <= 1'h1;
    @(posedge clk);
    gpe_a <= 1'h0;
    gpe_d <= 1'h0;
  endtask

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rd_valid === 1'h1) check(rdata, exp_q.size() > 0 ? exp_q.pop_front() : ~rdata);
    cnt[0] += (o_pa === 1'h1);
    cnt[1] += (o_pd === 1'h1);
    cnt[2] += (o_ga === 1'h1);
    cnt[3] += (o_gd === 1'h1);
  end

  initial begin
    #(20000 * 25);
    error_cnt++;
    $display("[ERR] t=%0t seen=%h exp=%h", $time, 32'h0000_0000, 32'h0000_0001);
    end_sim();
  end

  initial begin
    rst_n = 1'h0;
    {wr, rd, go, gpe_a, gpe_d} = 5'h00;
    addr = 12'h000;
    be = 4'h0;
    wdata = 32'h0000_0000;
    dev_err = 3'h0;
    msg_err = 3'h0;
    go_rid = 16'h0000;
    seed = 32'h28a6;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    cfg_read(rpc_pkg::ROOT_CONTROL_OFFSET, {16'h0000, rpc_pkg::ROOT_CONTROL_RESET});
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, rpc_pkg::ROOT_STATUS_RESET);
    cfg_read(rpc_pkg::LEGACY_EVENT_CONTROL_OFFSET, rpc_pkg::LEGACY_EVENT_CONTROL_RESET);
    cfg_read(12'h040, 32'h0000_0000);
    $display("test reset done");
    // Every pattern of the three system-error enables is tried, with the PME interrupt enable clear and random ones in the reserved bits.
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = {seed[31:4], 1'h0, i[2:0]};
      cfg_write(rpc_pkg::ROOT_CONTROL_OFFSET, 4'hf, d);
      cfg_read(rpc_pkg::ROOT_CONTROL_OFFSET, {28'h0, d[3:0]});
      for (int s = 0; s < 3; s++) begin
        for (int o = 0; o < 2; o++) err_pulse(s, o[0], d[s]);
      end
    end
    $display("test syserr done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      r[i] = seed[15:0];
    end
    cfg_write(rpc_pkg::ROOT_CONTROL_OFFSET, 4'hf, 32'h0000_0000);
    pme_send(r[0]);
    #1 check({31'h0, pme_int}, 32'h0000_0000);
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {15'h0, 1'h1, r[0]});
    pme_send(r[1]);
    pme_send(r[2]);
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {14'h0, 2'h3, r[0]});
    clear_sts();
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {14'h0, 2'h3, r[1]});
    clear_sts();
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {14'h0, 2'h1, r[2]});
    cfg_write(rpc_pkg::ROOT_CONTROL_OFFSET, 4'h1, 32'h0000_0008);
    @(posedge clk);
    #1 check({31'h0, pme_int}, 32'h0000_0001);
    clear_sts();
    repeat (2) @(posedge clk);
    #1 check({31'h0, pme_int}, 32'h0000_0000);
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {16'h0000, r[2]});
    pme_send(r[3]);
    #1 check({31'h0, pme_int}, 32'h0000_0001);
    // Four more fill the queue behind the set status, so the link must be refused.
    for (int i = 0; i < 4; i++) pme_send(r[i]);
    #1 check({31'h0, pme_ready}, 32'h0000_0000);
    for (int i = 0; i < 5; i++) clear_sts();
    cfg_read(rpc_pkg::ROOT_STATUS_OFFSET, {16'h0000, r[3]});
    $display("test pme done");
    cfg_write(rpc_pkg::LEGACY_EVENT_CONTROL_OFFSET, 4'hf, 32'hffff_ffff);
    cfg_read(rpc_pkg::LEGACY_EVENT_CONTROL_OFFSET, 32'h0000_0005);
    for (int en = 1; en >= 0; en--) begin
      cfg_write(rpc_pkg::LEGACY_EVENT_CONTROL_OFFSET, 4'h1, {29'h0, en[0], 1'h0, en[0]});
      base = cnt;
      pme_send(r[en]);
      clear_sts();
      gpe_pulse(1'h1);
      gpe_pulse(1'h0);
      repeat (3) @(posedge clk);
      #1 check(32'(cnt[0] - base[0]), 32'(en));
      check(32'(cnt[1] - base[1]), 32'(en));
      check(32'(cnt[2] - base[2]), 32'(en));
      check(32'(cnt[3] - base[3]), 32'(en));
    end
    $display("test legacy done");
    repeat (2) @(posedge clk);
    // A read whose answer never came leaves its note behind.
    check(32'(exp_q.size()), 32'h0000_0000);
    end_sim();
  end
endmodule // test_root_port_error_pme_control
`default_nettype wire
